// ===== epi_check_sva.sv
`timescale 1ns/1ps
`default_nettype none
module epi_check (
   input wire logic                  clock,
   input wire logic                  srst,
   input wire epi_pkg::epi_axi_req_t axi_req,
   input wire epi_pkg::epi_axi_rsp_t axi_rsp,
   input wire logic [23:0]           pin_change_inputs,
   input wire logic                  global_enable_in,
   input wire logic                  global_enable_load,
   input wire epi_pkg::epi_vec_t     core_request,
   input wire epi_pkg::epi_vec_t     core_ack
);
   logic [23:0] pins_q;
   logic [2:0]  quiet_q;
   logic [2:0]  calm_q;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // quiet: cycles since pins moved, so no event is still in the sync chain
   always_ff @(posedge clock) begin
      pins_q  <= pin_change_inputs;
      quiet_q <= (pin_change_inputs != pins_q) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
      calm_q  <= (srst || axi_req.wvalid || global_enable_load) ? 3'h0 :
                 calm_q + {2'h0, calm_q != 3'h7};
   end
   rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read answer missing");
   rd_stands_a: assert property (axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
   wr_stands_a: assert property (axi_rsp.bvalid && !axi_req.bready
      |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped");
   wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid) else $error("write answer missing");
   ar_refuse_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
      else $error("read accepted while answer pending");
   req_hold_a: assert property (
      core_request.bank0 && !core_ack.bank0 && !$past(core_ack.bank0) && calm_q > 3'h2
      |=> core_request.bank0) else $error("bank request dropped before ack");
   ack_clear_a: assert property (
      core_ack.bank0 && quiet_q > 3'h4 |-> ##[1:2] !core_request.bank0)
      else $error("bank request stays after ack");
   global_gate_a: assert property (
      global_enable_load && !global_enable_in |-> ##2 core_request == '0)
      else $error("request passes with global enable off");
endmodule
bind epi_external_pin_interrupt_unit epi_check i_epi_check (.clock(clock), .srst(srst),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .pin_change_inputs(pin_change_inputs),
   .global_enable_in(global_enable_in), .global_enable_load(global_enable_load),
   .core_request(core_request), .core_ack(core_ack));
`default_nettype wire

// ===== epi_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module epi_core_model (
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic [3:0]        ack_wait,
   input  wire epi_pkg::epi_vec_t core_request,
   output var epi_pkg::epi_vec_t  core_ack,
   output logic [7:0]             ack_cnt [5]
);
   logic [3:0] age [5];
   // a vector is taken after standing ack_wait cycles; age restarts while ack is high, so any wait avoids a double take
   always_ff @(posedge clock) begin
      for (int i = 0; i < 5; i++) begin
         core_ack[i] <= 1'b0;
         if (srst || !core_request[i] || core_ack[i]) begin
            age[i] <= 4'h0;
         end else if (age[i] == ack_wait) begin
            core_ack[i] <= 1'b1;
            ack_cnt[i]  <= ack_cnt[i] + 8'h1;
            age[i]      <= 4'h0;
         end else begin
            age[i] <= age[i] + 4'h1;
         end
         if (srst) ack_cnt[i] <= 8'h0;
      end
   end
endmodule
`default_nettype wire

// ===== epi_external_pin_interrupt_unit.sv
// Function
// - requests follow pin level even when the pin is driven as output
// - bank 2 is pins 23..16, bank 1 pins 14..8, bank 0 pins 7..0
// - a pin-change input counts only when its mask bit is set
// - pin-change events detected without the I/O clock, waking any sleep
// - enabled low-level pin keeps requesting while the pin stays low
// - edge sensing on dedicated pins needs the running I/O clock
// - low level on dedicated pins detected without clock for wake-up
// - low-level wake needs level held through start-up, else no interrupt
// - dedicated-pin request passes only with global and own enable set
// - dedicated pin is sampled first; edges compare sampled values
// - edge modes catch pulses wider than one clock period
// - sense 00 low, 01 any change, 10 falling, 11 rising
// - sense register: pin 1 in bits 3:2, pin 0 in bits 1:0
// - enable register: pin 1 bit 1, pin 0 bit 0, bits 7:2 read zero
// - sense register bits 7:4 read zero
// - pin-1 request goes to the core on its own vector
// - pin flag set on selected edge, cleared by handler or write-one, clear in level
// - bank flag set on any change, cleared by handler or write-one
// - bank request passes only with group enable and global enable
`timescale 1ns/1ps
`default_nettype none
module epi_external_pin_interrupt_unit (
   input  wire logic                 clock,
   input  wire logic                 srst,
   input  wire epi_pkg::epi_axi_req_t axi_req,
   output epi_pkg::epi_axi_rsp_t     axi_rsp,
   input  wire logic                 ext_request_pin0,
   input  wire logic                 ext_request_pin1,
   input  wire logic [23:0]          pin_change_inputs,
   input  wire logic                 global_enable_in,
   input  wire logic                 global_enable_load,
   output var logic                  async_wake,
   output epi_pkg::epi_vec_t         core_request,
   input  wire epi_pkg::epi_vec_t    core_ack
);

   epi_pkg::epi_state_t q;
   epi_pkg::epi_state_t d;

   logic [1:0]  pin_hit;
   logic [2:0]  bank_hit;
   logic [1:0]  level_req;
   logic [23:0] pc_change;
   logic [1:0]  pin_clr;
   logic [2:0]  group_clr;
   logic        wr_fire;
   logic        ar_fire;
   logic [7:0]  wr_idx;
   logic [7:0]  rd_idx;
   logic [7:0]  wbyte;
   logic [7:0]  rbyte;
   logic        rd_ok;
   logic        wr_ok;

   // clockless wake: low level on an enabled pin in low-level sense, or any masked pin differing from last seen
   always_comb begin
      async_wake = 1'b0;
      if (q.enable_mask[0] && q.sense[1:0] == 2'b00 && !ext_request_pin0) begin
         async_wake = 1'b1;
      end
      if (q.enable_mask[1] && q.sense[3:2] == 2'b00 && !ext_request_pin1) begin
         async_wake = 1'b1;
      end
      if (|((pin_change_inputs ^ q.pc_prev) & {q.mask_bank2, q.mask_bank1, q.mask_bank0})) begin
         async_wake = 1'b1;
      end
   end

   // edge and level decode per dedicated pin on synchronised samples
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         logic [1:0] s;
         logic       cur;
         logic       prv;
         s   = q.sense[2*i +: 2];
         cur = q.pin_s2[i];
         prv = q.pin_prev[i];
         level_req[i] = 1'b0;
         pin_hit[i]   = 1'b0;
         case (epi_pkg::epi_sense_t'(s))
            epi_pkg::EPI_SENSE_LOW:  level_req[i] = !cur;
            epi_pkg::EPI_SENSE_ANY:  pin_hit[i] = cur ^ prv;
            epi_pkg::EPI_SENSE_FALL: pin_hit[i] = prv & !cur;
            epi_pkg::EPI_SENSE_RISE: pin_hit[i] = !prv & cur;
            default:                 pin_hit[i] = 1'b0;
         endcase
      end
   end

   // masked change detect, one lane per pin-change input
   genvar g;
   generate
      for (g = 0; g < 24; g++) begin : g_pc
         logic mbit;
         if (g < 8) begin : g_b0
            assign mbit = q.mask_bank0[g];
         end else if (g < 16) begin : g_b1
            assign mbit = q.mask_bank1[g-8] & epi_pkg::BANK1_VALID_MASK[g-8];
         end else begin : g_b2
            assign mbit = q.mask_bank2[g-16];
         end
         assign pc_change[g] = (q.pc_s2[g] ^ q.pc_prev[g]) & mbit;
      end
   endgenerate

   assign bank_hit = {|pc_change[23:16], |pc_change[14:8], |pc_change[7:0]};

   // bus handshakes
   assign wr_fire = q.aw_held && q.w_held && !q.bvalid;
   assign ar_fire = axi_req.arvalid && !q.rvalid;
   assign wr_idx  = q.aw_addr[9:2];
   assign rd_idx  = axi_req.araddr[9:2];
   assign wbyte   = q.w_strb[0] ? q.w_data[7:0] : 8'h00;

   // register write decode
   always_comb begin
      wr_ok     = 1'b1;
      pin_clr   = 2'b00;
      group_clr = 3'b000;
      if (wr_fire) begin
         case (wr_idx)
            epi_pkg::IDX_FLAGS:        pin_clr   = wbyte[1:0];
            epi_pkg::IDX_GROUP_FLAGS:  group_clr = wbyte[2:0];
            epi_pkg::IDX_ENABLE_MASK,
            epi_pkg::IDX_SENSE_CONTROL,
            epi_pkg::IDX_GROUP_ENABLE,
            epi_pkg::IDX_MASK_BANK0,
            epi_pkg::IDX_MASK_BANK1,
            epi_pkg::IDX_MASK_BANK2,
            epi_pkg::IDX_GLOBAL_ENABLE,
            epi_pkg::IDX_PIN_LEVELS:   wr_ok = 1'b1;
            default:                   wr_ok = 1'b0;
         endcase
      end
      pin_clr   = pin_clr | {core_ack.pin1, core_ack.pin0};
      group_clr = group_clr | {core_ack.bank2, core_ack.bank1, core_ack.bank0};
   end

   // register read decode
   always_comb begin
      rd_ok = 1'b1;
      case (rd_idx)
         epi_pkg::IDX_ENABLE_MASK:   rbyte = {6'h00, q.enable_mask[1:0]};
         epi_pkg::IDX_SENSE_CONTROL: rbyte = {4'h0, q.sense};
         epi_pkg::IDX_FLAGS:         rbyte = {6'h00, q.pin_flag};
         epi_pkg::IDX_GROUP_ENABLE:  rbyte = {5'h00, q.group_enable};
         epi_pkg::IDX_GROUP_FLAGS:   rbyte = {5'h00, q.group_flag};
         epi_pkg::IDX_MASK_BANK0:    rbyte = q.mask_bank0;
         epi_pkg::IDX_MASK_BANK1:    rbyte = q.mask_bank1 & epi_pkg::BANK1_VALID_MASK;
         epi_pkg::IDX_MASK_BANK2:    rbyte = q.mask_bank2;
         epi_pkg::IDX_GLOBAL_ENABLE: rbyte = {7'h00, q.global_enable};
         epi_pkg::IDX_PIN_LEVELS:    rbyte = {6'h00, q.pin_s2};
         default: begin
            rbyte = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
   end

   // next state
   always_comb begin
      d = q;
      // two-flop synchronisers; prev holds the last sampled value
      d.pin_s1   = {ext_request_pin1, ext_request_pin0};
      d.pin_s2   = q.pin_s1;
      d.pin_prev = q.pin_s2;
      d.pc_s1    = pin_change_inputs;
      d.pc_s2    = q.pc_s1;
      d.pc_prev  = q.pc_s2;

      // flags: a set in the same cycle as a clear wins
      for (int i = 0; i < 2; i++) begin
         if (q.sense[2*i +: 2] == 2'b00) begin
            d.pin_flag[i] = 1'b0;
         end else if (pin_hit[i]) begin
            d.pin_flag[i] = 1'b1;
         end else if (pin_clr[i]) begin
            d.pin_flag[i] = 1'b0;
         end
      end
      for (int b = 0; b < 3; b++) begin
         if (bank_hit[b]) begin
            d.group_flag[b] = 1'b1;
         end else if (group_clr[b]) begin
            d.group_flag[b] = 1'b0;
         end
      end

      if (global_enable_load) begin
         d.global_enable = global_enable_in;
      end

      // write channel capture, either order
      if (axi_req.awvalid && !q.aw_held) begin
         d.aw_held = 1'b1;
         d.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !q.w_held) begin
         d.w_held = 1'b1;
         d.w_data = axi_req.wdata;
         d.w_strb = axi_req.wstrb;
      end
      if (wr_fire) begin
         d.aw_held = 1'b0;
         d.w_held  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = wr_ok ? epi_pkg::AXI_OKAY : epi_pkg::AXI_SLVERR;
         if (q.w_strb[0]) begin
            case (wr_idx)
               epi_pkg::IDX_ENABLE_MASK:   d.enable_mask = {6'h00, wbyte[1:0]};
               epi_pkg::IDX_SENSE_CONTROL: d.sense = wbyte[3:0];
               epi_pkg::IDX_GROUP_ENABLE:  d.group_enable = wbyte[2:0];
               epi_pkg::IDX_MASK_BANK0:    d.mask_bank0 = wbyte;
               epi_pkg::IDX_MASK_BANK1:    d.mask_bank1 = wbyte & epi_pkg::BANK1_VALID_MASK;
               epi_pkg::IDX_MASK_BANK2:    d.mask_bank2 = wbyte;
               epi_pkg::IDX_GLOBAL_ENABLE: d.global_enable = wbyte[0];
               default:                    d.bresp = d.bresp;
            endcase
         end
      end else if (q.bvalid && axi_req.bready) begin
         d.bvalid = 1'b0;
      end

      // read channel: one-cycle answer
      if (ar_fire) begin
         d.rvalid = 1'b1;
         d.rdata  = {24'h000000, rbyte};
         d.rresp  = rd_ok ? epi_pkg::AXI_OKAY : epi_pkg::AXI_SLVERR;
      end else if (q.rvalid && axi_req.rready) begin
         d.rvalid = 1'b0;
      end

      // requests toward the core, held until acknowledged via flag or level
      d.req.pin0  = q.global_enable & q.enable_mask[0]
                    & (d.pin_flag[0] | level_req[0]);
      d.req.pin1  = q.global_enable & q.enable_mask[1]
                    & (d.pin_flag[1] | level_req[1]);
      d.req.bank0 = q.global_enable & q.group_enable[0] & d.group_flag[0];
      d.req.bank1 = q.global_enable & q.group_enable[1] & d.group_flag[1];
      d.req.bank2 = q.global_enable & q.group_enable[2] & d.group_flag[2];
   end

   // state register; everything resets to zero
   always_ff @(posedge clock) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // bus outputs; ready only while a slot is free
   always_comb begin
      axi_rsp.awready = !q.aw_held;
      axi_rsp.wready  = !q.w_held;
      axi_rsp.bvalid  = q.bvalid;
      axi_rsp.bresp   = q.bresp;
      axi_rsp.arready = !q.rvalid;
      axi_rsp.rvalid  = q.rvalid;
      axi_rsp.rdata   = q.rdata;
      axi_rsp.rresp   = q.rresp;
   end

   assign core_request = q.req;

endmodule
`default_nettype wire

// ===== epi_pkg.sv
package epi_pkg;
   // register word indices (printed offsets are not all multiples of four: index times four)
   localparam logic [7:0] IDX_ENABLE_MASK   = 8'h1d;
   localparam logic [7:0] IDX_SENSE_CONTROL = 8'h20;
   localparam logic [7:0] IDX_FLAGS         = 8'h1c;
   localparam logic [7:0] IDX_GROUP_ENABLE  = 8'h68;
   localparam logic [7:0] IDX_GROUP_FLAGS   = 8'h1b;
   localparam logic [7:0] IDX_MASK_BANK0    = 8'h6b;
   localparam logic [7:0] IDX_MASK_BANK1    = 8'h6c;
   localparam logic [7:0] IDX_MASK_BANK2    = 8'h6d;
   localparam logic [7:0] IDX_GLOBAL_ENABLE = 8'h3f;
   localparam logic [7:0] IDX_PIN_LEVELS    = 8'h21;
   localparam int         ADDR_W            = 10;
   localparam int         SENSE_PIN0_LSB    = 0;
   localparam int         SENSE_PIN1_LSB    = 2;
   localparam logic [7:0] RESET_VALUE       = 8'h00;
   localparam logic [7:0] BANK1_VALID_MASK  = 8'h7f;
   localparam logic [1:0] AXI_OKAY          = 2'b00;
   localparam logic [1:0] AXI_SLVERR        = 2'b10;

   // sense field encodings
   typedef enum logic [1:0] {
      EPI_SENSE_LOW  = 2'b00,
      EPI_SENSE_ANY  = 2'b01,
      EPI_SENSE_FALL = 2'b10,
      EPI_SENSE_RISE = 2'b11
   } epi_sense_t;

   // request / acknowledge vector toward the core: 0,1 pins, 2..4 banks 0..2
   typedef struct packed {
      logic       bank2;
      logic       bank1;
      logic       bank0;
      logic       pin1;
      logic       pin0;
   } epi_vec_t;

   typedef enum logic [1:0] {EPI_WR_IDLE, EPI_WR_RESP} epi_wr_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic              awvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [ADDR_W-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } epi_axi_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic [1:0]        bresp;
      logic              bvalid;
      logic              arready;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic              rvalid;
   } epi_axi_rsp_t;

   typedef struct packed {
      logic [7:0]        enable_mask;
      logic [3:0]        sense;
      logic [2:0]        group_enable;
      logic [7:0]        mask_bank0;
      logic [7:0]        mask_bank1;
      logic [7:0]        mask_bank2;
      logic              global_enable;
      logic [1:0]        pin_flag;
      logic [2:0]        group_flag;
      logic [1:0]        pin_s1;
      logic [1:0]        pin_s2;
      logic [1:0]        pin_prev;
      logic [23:0]       pc_s1;
      logic [23:0]       pc_s2;
      logic [23:0]       pc_prev;
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      epi_vec_t          req;
   } epi_state_t;
endpackage

// ===== test_external_pin_interrupt_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_external_pin_interrupt_unit;
   logic                  clock, srst, p0, p1, ge_in, ge_ld, wake;
   logic [23:0]           pci;
   logic [3:0]            ack_wait;
   epi_pkg::epi_axi_req_t rq;
   epi_pkg::epi_axi_rsp_t rs;
   epi_pkg::epi_vec_t     req, ack;
   logic [7:0]            acks [5];
   logic [31:0]           rd;
   logic [1:0]            rsp;
   int                    fails, n_tests, cyc_n;

   epi_external_pin_interrupt_unit i_epi_external_pin_interrupt_unit (.clock(clock),
      .srst(srst), .axi_req(rq), .axi_rsp(rs), .ext_request_pin0(p0), .ext_request_pin1(p1),
      .pin_change_inputs(pci), .global_enable_in(ge_in), .global_enable_load(ge_ld),
      .async_wake(wake), .core_request(req), .core_ack(ack));
   epi_core_model i_epi_core_model (.clock(clock), .srst(srst), .ack_wait(ack_wait),
      .core_request(req), .core_ack(ack), .ack_cnt(acks));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clock) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         fails++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (fails == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   // each bus task starts one edge on, so releases never collide with a new request
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge clock);
      rq.awaddr <= {idx, 2'h0};
      rq.wdata <= {24'h0, d};
      rq.wstrb <= 4'hf;
      rq.awvalid <= 1'b1;
      rq.wvalid <= 1'b1;
      rq.bready <= 1'b1;
      do begin
         @(posedge clock);
         if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
         if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
      end while (rs.bvalid !== 1'b1);
      chk(rs.bresp, epi_pkg::AXI_OKAY);
      rq.bready <= 1'b0;
   endtask

   task automatic rdreg(input logic [7:0] idx);
      @(posedge clock);
      rq.araddr <= {idx, 2'h0};
      rq.arvalid <= 1'b1;
      rq.rready <= 1'b1;
      do begin
         @(posedge clock);
         if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
      end while (rs.rvalid !== 1'b1);
      rd = rs.rdata;
      rsp = rs.rresp;
      rq.rready <= 1'b0;
   endtask

   // pins are held well over one clock, as the far side must
   task automatic drive(input logic a, input logic b, input logic [23:0] c, input int n);
      @(posedge clock);
      p0 <= a;
      p1 <= b;
      pci <= c;
      repeat (n) @(posedge clock);
   endtask

   task automatic set_ge(input logic v);
      @(posedge clock);
      ge_in <= v;
      ge_ld <= 1'b1;
      @(posedge clock);
      ge_ld <= 1'b0;
   endtask

   task automatic t_regs();
      rdreg(epi_pkg::IDX_ENABLE_MASK);
      chk(rd, 32'h0);
      wr(epi_pkg::IDX_SENSE_CONTROL, 8'hff);
      rdreg(epi_pkg::IDX_SENSE_CONTROL);
      chk(rd, 32'h0f);
      wr(epi_pkg::IDX_ENABLE_MASK, 8'hff);
      rdreg(epi_pkg::IDX_ENABLE_MASK);
      chk(rd, 32'h03);
      wr(epi_pkg::IDX_ENABLE_MASK, 8'h00);
      wr(epi_pkg::IDX_MASK_BANK1, 8'hff);
      rdreg(epi_pkg::IDX_MASK_BANK1);
      chk(rd, 32'h7f);
      rdreg(8'h00);
      chk(rsp, epi_pkg::AXI_SLVERR);
   endtask

   // every sense code on both pins; global enable is off so flags are not taken
   task automatic t_sense();
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         wr(epi_pkg::IDX_SENSE_CONTROL, {4'h0, m, m});
         drive(1'b0, 1'b0, pci, 6);
         wr(epi_pkg::IDX_FLAGS, 8'h03);
         drive(1'b1, 1'b1, pci, 6);
         rdreg(epi_pkg::IDX_FLAGS);
         chk(rd, (m == 2'b01 || m == 2'b11) ? 32'h3 : 32'h0);
         wr(epi_pkg::IDX_FLAGS, 8'h03);
         rdreg(epi_pkg::IDX_FLAGS);
         chk(rd, 32'h0);
         drive(1'b0, 1'b0, pci, 6);
         rdreg(epi_pkg::IDX_FLAGS);
         chk(rd, (m == 2'b01 || m == 2'b10) ? 32'h3 : 32'h0);
      end
   endtask

   task automatic t_level();
      drive(1'b1, 1'b0, pci, 4);
      wr(epi_pkg::IDX_SENSE_CONTROL, 8'h00);
      wr(epi_pkg::IDX_ENABLE_MASK, 8'h01);
      set_ge(1'b1);
      drive(1'b0, 1'b0, pci, 8);
      chk(req.pin0, 1'b1);
      chk(wake, 1'b1);
      repeat (8) @(posedge clock);
      chk(req.pin0, 1'b1);
      rdreg(epi_pkg::IDX_FLAGS);
      chk(rd, 32'h0);
      set_ge(1'b0);
      repeat (3) @(posedge clock);
      chk(req.pin0, 1'b0);
      drive(1'b1, 1'b0, pci, 4);
      set_ge(1'b1);
   endtask

   // pin 1 on its own vector, taken by a slow core
   task automatic t_vec();
      logic [7:0] c0, c1;
      wr(epi_pkg::IDX_SENSE_CONTROL, 8'h0c);
      wr(epi_pkg::IDX_ENABLE_MASK, 8'h02);
      ack_wait <= 4'h5;
      c0 = acks[0];
      c1 = acks[1];
      drive(1'b1, 1'b1, pci, 14);
      chk(acks[1], c1 + 8'h1);
      chk(acks[0], c0);
      wr(epi_pkg::IDX_ENABLE_MASK, 8'h00);
      ack_wait <= 4'h2;
   endtask

   task automatic t_bank();
      logic [7:0] c;
      wr(epi_pkg::IDX_GROUP_ENABLE, 8'h07);
      wr(epi_pkg::IDX_MASK_BANK0, 8'h01);
      wr(epi_pkg::IDX_MASK_BANK1, 8'h01);
      wr(epi_pkg::IDX_MASK_BANK2, 8'h01);
      for (int b = 0; b < 3; b++) begin
         c = acks[2+b];
         drive(p0, p1, pci ^ (24'h2 << (8 * b)), 10);
         chk(acks[2+b], c);
         drive(p0, p1, pci ^ (24'h1 << (8 * b)), 10);
         chk(acks[2+b], c + 8'h1);
      end
      wr(epi_pkg::IDX_GROUP_ENABLE, 8'h00);
      c = acks[2];
      drive(p0, p1, pci ^ 24'h1, 10);
      chk(acks[2], c);
      rdreg(epi_pkg::IDX_GROUP_FLAGS);
      chk(rd, 32'h1);
      wr(epi_pkg::IDX_GROUP_FLAGS, 8'h07);
      rdreg(epi_pkg::IDX_GROUP_FLAGS);
      chk(rd, 32'h0);
      // clockless wake shows before the sync chain has seen the change
      pci <= pci ^ 24'h1;
      @(posedge clock);
      chk(wake, 1'b1);
   endtask

   initial begin
      srst = 1'b1;
      p0 = 1'b1;
      p1 = 1'b0;
      pci = 24'h0;
      ge_in = 1'b0;
      ge_ld = 1'b0;
      ack_wait = 4'h2;
      rq = '0;
      fails = 0;
      n_tests = 0;
      cyc_n = 0;
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      t_regs();
      t_sense();
      t_level();
      t_vec();
      t_bank();
      end_sim();
   end
endmodule
`default_nettype wire
